/* File: design/rtc_counter_and_osc_control.sv */
// RTC counter chain, subsecond alarm and slow clock input control with AXI4-Lite registers
`timescale 1ns/1ps
`include "rtc_regs.svh"

// Summary of operation
// - Bypass set disables oscillator, external clock used
// - Internal oscillator needs 250 ms warm-up
// - Bypass writable only while RTC disabled
// - Ready flag set after warm-up, read-only
// - Ready cleared by disable, or by mode change outside bypass
// - Input disable stops slow circuitry, RTC-off only
// - Slow source stays running in stop mode
// - Enable and trim writable only when unprotected
// - Counters, alarm reload and alarm timer survive every reset
// - Counter writes need RTC off, not busy
// - Subsecond counter counts 256 Hz ticks
// - Subsecond rollover increments 32-bit seconds
// - Seconds exposed as high and low halves
// - Alarm reload writable when idle and stopped
// - Alarm autoreload sets the alarm flag
// - Unmasked enabled alarm flag raises interrupt
module rtc_counter_and_osc_control
   import rtc_pkg::*;
#(parameter int unsigned WARMUP_CYCLES = `RTC_WARMUP_CYCLES) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Slow clock pin and oscillator controls
   input wire logic crystal_in,
   output logic osc_internal_enable,
   output logic slow_circuit_enable,
   output logic slow_clock_ready,
   // Interrupt
   output logic irq
);
   // ==========================================
   // State declarations
   logic [9:0] aw_index_reg; // Write index
   logic aw_hold_reg, w_hold_reg; // Halves held
   logic [31:0] w_data_reg, seconds_reg, warm_count_reg; // Write data, seconds, warm-up count
   logic [3:0] w_strb_reg; // Byte enables
   logic rtc_enable_reg, alarm_enable_reg; // Chain, alarm running
   osc_ctrl_t osc_reg; // Oscillator controls
   logic [7:0] trim_reg, reload_reg, alarm_timer_reg, subsec_reg; // Trim, alarm, subseconds
   logic flag_reg, mask_reg; // Alarm flag, mask
   logic busy_reg, ready_reg; // Transfer, stable
   pend_t pend_reg; // Pending counter write
   logic [6:0] prescale_reg; // Slow edges per tick
   logic [2:0] sync_reg; // Pin synchroniser
   logic slow_level_reg; // Filtered pin level
   osc_state_t osc_state_reg; // Warm-up state
   // ==========================================
   // Combinational decode
   logic do_write, wr_ok, rd_ok, ctrl_wr, cnt_wr_ok; // Write terms
   logic [31:0] wr_word, wr_old, rd_word; // Merged, current, read
   logic slow_edge, tick, count_en, alarm_hit; // Chain terms
   logic warm_restart, apply_pend; // Warm again, load
   osc_ctrl_t osc_next; // Control after write
   // Register readback, shared by read channel and byte merge
   function automatic logic [32:0] readback(input logic [9:0] idx);
      logic [32:0] r;
      r = {1'h1, 32'h0000_0000};
      case (idx)
         `RTC_IDX_CONTROL: begin
            r[`RTC_CTRL_ENABLE_BIT] = rtc_enable_reg;
            r[`RTC_CTRL_ALARM_EN_BIT] = alarm_enable_reg;
            r[`RTC_CTRL_BUSY_BIT] = busy_reg;
            r[`RTC_CTRL_READY_BIT] = ready_reg;
            r[`RTC_CTRL_FLAG_BIT] = flag_reg;
            r[`RTC_CTRL_MODE_LSB +: 2] = osc_reg.mode;
            r[`RTC_CTRL_BYPASS_BIT] = osc_reg.bypass;
            r[`RTC_CTRL_SLOW_RDY_BIT] = slow_clock_ready;
            r[`RTC_CTRL_DISABLE_BIT] = osc_reg.disable_in;
            r[`RTC_CTRL_WREN_BIT] = osc_reg.wren;
         end
         `RTC_IDX_SUBSEC: r[7:0] = subsec_reg; // Always readable
         `RTC_IDX_SEC_HIGH: r[15:0] = seconds_reg[31:16];
         `RTC_IDX_SEC_LOW: r[15:0] = seconds_reg[15:0];
         `RTC_IDX_ALARM_RELOAD: r[7:0] = reload_reg;
         `RTC_IDX_INT_STATUS: r[`RTC_STAT_FLAG_BIT] = flag_reg;
         `RTC_IDX_INT_MASK: r[`RTC_STAT_FLAG_BIT] = mask_reg;
         `RTC_IDX_TRIM: r[7:0] = trim_reg;
         default: r[32] = 1'h0; // Unmapped
      endcase
      return r;
   endfunction
   // Write strobe and merge; refused writes still answer OKAY
   always_comb begin
      do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
      {wr_ok, wr_old} = readback(aw_index_reg);
      {rd_ok, rd_word} = readback(s_axi_araddr[11:2]);
      for (int i = 0; i < 4; i++) begin
         wr_word[8*i +: 8] = w_strb_reg[i] ? w_data_reg[8*i +: 8] : wr_old[8*i +: 8];
      end
      ctrl_wr = do_write && (aw_index_reg == `RTC_IDX_CONTROL);
      cnt_wr_ok = do_write && !rtc_enable_reg && !busy_reg;
   end
   // Next oscillator controls; bypass and disable locked while the RTC runs
   always_comb begin
      osc_next = osc_reg;
      if (ctrl_wr) begin
         osc_next.wren = wr_word[`RTC_CTRL_WREN_BIT];
         osc_next.mode = wr_word[`RTC_CTRL_MODE_LSB +: 2];
         if (!rtc_enable_reg) begin
            osc_next.bypass = wr_word[`RTC_CTRL_BYPASS_BIT];
            osc_next.disable_in = wr_word[`RTC_CTRL_DISABLE_BIT];
         end
      end
   end
   // Chain timing; warm-up restarts when the oscillator turns on or its mode changes
   always_comb begin
      warm_restart = !osc_next.disable_in && !osc_next.bypass
         && (osc_reg.disable_in || osc_reg.bypass || (osc_next.mode != osc_reg.mode));
      slow_edge = sync_reg[2] && sync_reg[1] && !slow_level_reg && !osc_reg.disable_in;
      tick = slow_edge && (prescale_reg == 7'(`RTC_PRESCALE_DIV - 1));
      count_en = rtc_enable_reg && slow_clock_ready && !busy_reg;
      alarm_hit = tick && count_en && alarm_enable_reg && (alarm_timer_reg == 8'h00);
      apply_pend = busy_reg && (slow_edge || osc_reg.disable_in);
   end
   // ==========================================
   // AXI4-Lite write channels: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'h0;
         aw_index_reg <= 10'h000;
         s_axi_awready <= 1'h1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_reg <= 1'h1;
         aw_index_reg <= s_axi_awaddr[11:2];
         s_axi_awready <= 1'h0;
      end else if (do_write) begin
         aw_hold_reg <= 1'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'h1; // Reopen after response
      end
   end
   // Write data holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_reg <= 1'h0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_wready <= 1'h1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_reg <= 1'h1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
         s_axi_wready <= 1'h0;
      end else if (do_write) begin
         w_hold_reg <= 1'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'h1;
      end
   end
   // Write response, one cycle after both halves held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= `RTC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'h1;
         s_axi_bresp <= wr_ok ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'h0;
      end
   end
   // Read channel, data one cycle after address taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'h1;
         s_axi_rvalid <= 1'h0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RTC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid <= 1'h1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'h0;
         s_axi_arready <= 1'h1;
      end
   end
   // ==========================================
   // Control register; enable and trim locked unless unprotected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rtc_enable_reg <= 1'h0;
         alarm_enable_reg <= 1'h0;
         trim_reg <= `RTC_RST_TRIM;
         osc_reg <= '{wren: 1'h0, disable_in: 1'h0, bypass: 1'h0, mode: `RTC_RST_MODE};
      end else begin
         osc_reg <= osc_next;
         if (ctrl_wr) begin
            alarm_enable_reg <= wr_word[`RTC_CTRL_ALARM_EN_BIT];
            if (osc_reg.wren) begin
               rtc_enable_reg <= wr_word[`RTC_CTRL_ENABLE_BIT];
            end
         end
         if (do_write && (aw_index_reg == `RTC_IDX_TRIM) && osc_reg.wren) begin
            trim_reg <= wr_word[7:0];
         end
      end
   end
   // Sticky alarm flag and mask; a set beats a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 1'h0;
         mask_reg <= `RTC_RST_MASK;
      end else begin
         if (alarm_hit) begin
            flag_reg <= 1'h1;
         end else if (do_write && (aw_index_reg == `RTC_IDX_INT_STATUS) && wr_word[`RTC_STAT_FLAG_BIT]) begin
            flag_reg <= 1'h0; // Write one to clear
         end
         if (do_write && (aw_index_reg == `RTC_IDX_INT_MASK)) begin
            mask_reg <= wr_word[`RTC_STAT_FLAG_BIT];
         end
      end
   end
   // Interrupt level from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'h0;
      end else begin
         irq <= flag_reg && mask_reg && alarm_enable_reg;
      end
   end
   // ==========================================
   // Counter write transfer; lands in the chain on a slow edge, or at once while the input is disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_reg <= 1'h0;
         ready_reg <= 1'h1;
         pend_reg <= '0;
      end else if (apply_pend) begin
         busy_reg <= 1'h0;
         ready_reg <= 1'h0; // Settle one cycle after the load
         pend_reg <= '0;
      end else if (cnt_wr_ok && (aw_index_reg inside {`RTC_IDX_SUBSEC, `RTC_IDX_SEC_HIGH, `RTC_IDX_SEC_LOW})) begin
         busy_reg <= 1'h1;
         ready_reg <= 1'h0;
         pend_reg.sub_v <= (aw_index_reg == `RTC_IDX_SUBSEC);
         pend_reg.high_v <= (aw_index_reg == `RTC_IDX_SEC_HIGH);
         pend_reg.low_v <= (aw_index_reg == `RTC_IDX_SEC_LOW);
         pend_reg.data <= wr_word[15:0];
      end else begin
         ready_reg <= !busy_reg && !tick; // Not stable while the chain ripples
      end
   end
   // Counter chain; no reset so values survive every reset
   always_ff @(posedge aclk) begin
      if (apply_pend) begin
         if (pend_reg.sub_v) begin
            subsec_reg <= pend_reg.data[7:0];
         end
         if (pend_reg.high_v) begin
            seconds_reg[31:16] <= pend_reg.data;
         end
         if (pend_reg.low_v) begin
            seconds_reg[15:0] <= pend_reg.data;
         end
      end else if (tick && count_en) begin
         subsec_reg <= subsec_reg + 8'h01;
         if (subsec_reg == 8'hFF) begin
            seconds_reg <= seconds_reg + 32'h0000_0001;
         end
      end
   end
   // Alarm reload and timer, also kept through reset
   always_ff @(posedge aclk) begin
      if (do_write && (aw_index_reg == `RTC_IDX_ALARM_RELOAD) && !busy_reg
          && (!alarm_enable_reg || !rtc_enable_reg)) begin
         reload_reg <= wr_word[7:0];
         alarm_timer_reg <= wr_word[7:0]; // Restart, so it never counts from an unknown value
      end
      if (alarm_hit) begin
         alarm_timer_reg <= reload_reg; // Autoreload
      end else if (tick && count_en && alarm_enable_reg) begin
         alarm_timer_reg <= alarm_timer_reg - 8'h01;
      end
   end
   // ==========================================
   // Pin sampling; crystal or external clock share this path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_reg <= 3'h0;
         slow_level_reg <= 1'h0;
      end else begin
         sync_reg <= {sync_reg[1:0], crystal_in};
         if (sync_reg[2] == sync_reg[1]) begin
            slow_level_reg <= sync_reg[2]; // Stages two and three agree
         end
      end
   end
   // Prescaler from slow edges to 256 Hz
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale_reg <= 7'h00;
      end else if (slow_edge) begin
         prescale_reg <= prescale_reg + 7'h01; // Wraps at the divide count
      end
   end
   // Warm-up state machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_state_reg <= OSC_WARM;
         warm_count_reg <= 32'h0000_0000;
      end else if (osc_next.disable_in) begin
         osc_state_reg <= OSC_OFF;
         warm_count_reg <= 32'h0000_0000;
      end else if (warm_restart) begin
         osc_state_reg <= OSC_WARM;
         warm_count_reg <= 32'h0000_0000;
      end else begin
         case (osc_state_reg)
            OSC_OFF: begin
               osc_state_reg <= osc_next.bypass ? OSC_READY : OSC_WARM;
            end
            OSC_WARM: begin
               if (osc_reg.bypass || (warm_count_reg >= WARMUP_CYCLES - 1)) begin
                  osc_state_reg <= OSC_READY;
               end else begin
                  warm_count_reg <= warm_count_reg + 32'h0000_0001;
               end
            end
            OSC_READY: osc_state_reg <= OSC_READY;
            default: osc_state_reg <= OSC_OFF;
         endcase
      end
   end
   // Oscillator outputs; no stop-mode term, so the source runs in stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_internal_enable <= 1'h0;
         slow_circuit_enable <= 1'h0;
         slow_clock_ready <= 1'h0;
      end else begin
         osc_internal_enable <= !osc_reg.disable_in && !osc_reg.bypass;
         slow_circuit_enable <= !osc_reg.disable_in;
         slow_clock_ready <= (osc_state_reg == OSC_READY) && !osc_next.disable_in && !warm_restart;
      end
   end
endmodule // rtc_counter_and_osc_control

/* File: design/rtc_regs.svh */
// Register indices, field positions, reset values and timing counts of the RTC block
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
// ==========================================
// Register indices (byte address = 4 * index)
`define RTC_IDX_CONTROL 10'h019
`define RTC_IDX_SUBSEC 10'h01A
`define RTC_IDX_SEC_HIGH 10'h01B
`define RTC_IDX_SEC_LOW 10'h01C
`define RTC_IDX_ALARM_RELOAD 10'h01D
`define RTC_IDX_INT_STATUS 10'h020
`define RTC_IDX_INT_MASK 10'h021
`define RTC_IDX_TRIM 10'h022
// ==========================================
// Control register field positions
`define RTC_CTRL_ENABLE_BIT 0
`define RTC_CTRL_ALARM_EN_BIT 1
`define RTC_CTRL_BUSY_BIT 3
`define RTC_CTRL_READY_BIT 4
`define RTC_CTRL_FLAG_BIT 7
`define RTC_CTRL_MODE_LSB 10
`define RTC_CTRL_BYPASS_BIT 12
`define RTC_CTRL_SLOW_RDY_BIT 13
`define RTC_CTRL_DISABLE_BIT 14
`define RTC_CTRL_WREN_BIT 15
`define RTC_STAT_FLAG_BIT 0
// ==========================================
// Reset values
`define RTC_RST_MODE 2'h0
`define RTC_RST_TRIM 8'h00
`define RTC_RST_MASK 1'h0
// ==========================================
// Timing
`define RTC_CLK_MHZ 250
`define RTC_WARMUP_MS 250
`define RTC_WARMUP_CYCLES (`RTC_WARMUP_MS * 1000 * `RTC_CLK_MHZ)
`define RTC_SLOW_HZ 32768
`define RTC_TICK_HZ 256
`define RTC_PRESCALE_DIV (`RTC_SLOW_HZ / `RTC_TICK_HZ)
// ==========================================
// Bus responses
`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2
`endif

/* File: design/rtc_pkg.sv */
// Types shared by the RTC counter and oscillator control block
package rtc_pkg;
   // Oscillator warm-up states
   typedef enum logic [1:0] {OSC_OFF, OSC_WARM, OSC_READY} osc_state_t;
   // Software write waiting to enter the counter chain
   typedef struct packed {
      logic sub_v;
      logic high_v;
      logic low_v;
      logic [15:0] data;
   } pend_t;
   // Oscillator control fields
   typedef struct packed {
      logic wren;
      logic disable_in;
      logic bypass;
      logic [1:0] mode;
   } osc_ctrl_t;
endpackage

/* File: test/rtc_counter_and_osc_control_assertions.sv */
// Concurrent checks on the pins of the RTC counter and slow clock block
`timescale 1ns/1ps
// ==========================================
// Checker module
module rtc_counter_and_osc_control_assertions #(
   parameter int unsigned WARMUP_CYCLES = 20
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Oscillator pins and interrupt
   input wire logic osc_internal_enable,
   input wire logic slow_circuit_enable,
   input wire logic slow_clock_ready,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Oscillator-on cycles, saturating
   logic [31:0] warm_cnt;
   // ==========================================
   // Warm-up span counter
   always_ff @(posedge aclk) begin
      if (!aresetn || !osc_internal_enable) begin
         warm_cnt <= 32'h0;
      end else if (warm_cnt != 32'hFFFFFFFF) begin
         warm_cnt <= warm_cnt + 32'h1;
      end
   end
   // ==========================================
   // Oscillator and ready flag
   AST_WARMUP_SPAN: assert property (slow_clock_ready && osc_internal_enable && $past(osc_internal_enable)
      |-> warm_cnt >= WARMUP_CYCLES - 2) else $error("early slow ready");
   AST_OSC_NEEDS_CIRCUIT: assert property (osc_internal_enable |-> slow_circuit_enable)
      else $error("oscillator without input");
   AST_READY_DROPS_ON_DISABLE: assert property (!slow_circuit_enable ##1 !slow_circuit_enable
      |-> !slow_clock_ready) else $error("ready while disabled");
   AST_READY_RISES_ENABLED: assert property ($rose(slow_clock_ready) |-> slow_circuit_enable)
      else $error("ready rose while off");
   // ==========================================
   // Register bus answers
   AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid) else $error("late write answer");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("late read data");
   AST_RESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("response dropped");
   AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed");
   // ==========================================
   // Scenario coverage
   COV_READY: cover property ($rose(slow_clock_ready));
   COV_IRQ: cover property ($rose(irq));
   COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
   COV_BYPASS: cover property ($fell(osc_internal_enable) && slow_circuit_enable);
endmodule // rtc_counter_and_osc_control_assertions

/* File: test/slow_clock_source.sv */
// Model of the 32 kHz crystal or external clock feeding the slow pin
`timescale 1ns/1ps
// ==========================================
// Slow clock source
module slow_clock_source #(
   parameter int HALF = 3
) (
   // Fast reference for timing only
   input wire logic aclk,
   // Slow input circuitry on
   input wire logic circuit_on,
   // Slow clock pin
   output logic crystal_in
);
   // Pin level and half-period count
   logic level = 1'b0;
   int cnt = 0;
   assign crystal_in = level;
   // Toggles while accepted, stop mode included
   always @(posedge aclk) begin
      if (!circuit_on) begin
         // No clock accepted while disabled
         level <= 1'b0;
         cnt <= 0;
      end else if (cnt == HALF - 1) begin
         // Crystal or external clock alike
         level <= ~level;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // slow_clock_source

/* File: test/rtc_counter_and_osc_control_bench.sv */
// Self-checking bench for the RTC counter and slow clock control block
`timescale 1ns/1ps
`include "rtc_regs.svh"
// ==========================================
// Bench top
module rtc_counter_and_osc_control_bench;
   // Shortened warm-up so the run stays short
   localparam int unsigned WARMUP_CYCLES = 20;
   logic aclk, aresetn;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, resp;
   logic crystal_in, osc_en, circ_en, slow_rdy, irq;
   // Scoreboard counters
   int failures = 0;
   int compares = 0;
   // Random source and behavioural register model
   logic [31:0] rnd = 32'h3707;
   logic [31:0] m_ctrl = 32'h0, m_trim = 32'h0, m_reload = 32'h0, rd_v;
   // ==========================================
   // Design and slow clock partner
   rtc_counter_and_osc_control #(.WARMUP_CYCLES(WARMUP_CYCLES)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .crystal_in(crystal_in), .osc_internal_enable(osc_en),
      .slow_circuit_enable(circ_en), .slow_clock_ready(slow_rdy), .irq(irq));
   slow_clock_source #(.HALF(3)) src (.aclk(aclk), .circuit_on(circ_en), .crystal_in(crystal_in));
   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write one word; address and data released as each is taken
   task automatic wr(input int idx, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= 32'(idx * 4);
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
      // Model: protected and locked fields keep their old value
      case (idx)
         `RTC_IDX_CONTROL: m_ctrl = (d & 32'h8C02) | (m_ctrl[15] ? d & 32'h1 : m_ctrl & 32'h1)
            | (m_ctrl[0] ? m_ctrl & 32'h5000 : d & 32'h5000);
         `RTC_IDX_TRIM: if (m_ctrl[15]) m_trim = d & 32'hFF;
         `RTC_IDX_ALARM_RELOAD: if (!(m_ctrl[1] && m_ctrl[0])) m_reload = d & 32'hFF;
         default: ;
      endcase
   endtask
   // Read one word into rd_v and resp
   task automatic rd(input int idx);
      @(posedge aclk);
      araddr <= 32'(idx * 4);
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rd_v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // Bounded wait for the slow source, then confirm it came
   task automatic wait_rdy;
      int n = 0;
      while (slow_rdy !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      chk({31'h0, slow_rdy}, 32'h1);
   endtask
   // Poll the busy bit until a counter write has crossed
   task automatic wait_idle;
      int n = 0;
      rd(`RTC_IDX_CONTROL);
      while (rd_v[`RTC_CTRL_BUSY_BIT] !== 1'b0 && n < 20) begin
         rd(`RTC_IDX_CONTROL);
         n++;
      end
   endtask
   task automatic end_sim;
      if (failures == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hang guard, well beyond the expected few thousand cycles
   initial begin
      repeat (30000) @(posedge aclk);
      failures++;
      end_sim;
   end
   // ==========================================
   // Main sequence
   initial begin
      int idx[3];
      logic [31:0] val[3];
      idx = '{`RTC_IDX_SUBSEC, `RTC_IDX_SEC_HIGH, `RTC_IDX_SEC_LOW};
      val = '{32'hFE, 32'h1234, 32'hFFFF};
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wait_rdy;
      // Protection: enable and trim locked until the write enable is set
      wr(`RTC_IDX_CONTROL, 32'h2001);
      rd(`RTC_IDX_CONTROL);
      chk(rd_v & 32'hFC03, m_ctrl | 32'h2000);
      for (int i = 0; i < 4; i++) begin
         if (i == 1) wr(`RTC_IDX_CONTROL, 32'h8000);
         rnd = lfsr(rnd);
         wr(`RTC_IDX_TRIM, rnd);
         rd(`RTC_IDX_TRIM);
         chk(rd_v, m_trim);
      end
      // Unmapped place answers with an error
      rd(10'h01F);
      chk({30'h0, resp}, {30'h0, `RTC_RESP_SLVERR});
      // Load the chain just below a carry into the high half
      for (int i = 0; i < 3; i++) begin
         wr(idx[i], val[i]);
         wait_idle;
         rd(idx[i]);
         chk(rd_v, val[i]);
      end
      wr(`RTC_IDX_ALARM_RELOAD, 32'h0);
      wr(`RTC_IDX_INT_MASK, 32'h0);
      // Start only once the slow source is ready
      wr(`RTC_IDX_CONTROL, 32'h8003);
      // Locked while running: bypass, disable, counters, reload
      wr(`RTC_IDX_CONTROL, 32'hD003);
      wr(`RTC_IDX_SUBSEC, 32'h11);
      wr(`RTC_IDX_ALARM_RELOAD, 32'h33);
      rd(`RTC_IDX_CONTROL);
      chk(rd_v & 32'hDC03, m_ctrl);
      chk({30'h0, osc_en, circ_en}, 32'h3);
      rd(`RTC_IDX_ALARM_RELOAD);
      chk(rd_v, m_reload);
      // Roughly 2.3 ticks of 128 slow edges, then stop and read
      repeat (300) @(posedge crystal_in);
      wr(`RTC_IDX_CONTROL, 32'h8002);
      rd(`RTC_IDX_SUBSEC);
      chk(rd_v & 32'hFFFFFFFE, 32'h0);
      rd(`RTC_IDX_SEC_HIGH);
      chk(rd_v, 32'h1235);
      rd(`RTC_IDX_SEC_LOW);
      chk(rd_v, 32'h0);
      // Alarm flag set, masked, unmasked, cleared
      rd(`RTC_IDX_INT_STATUS);
      chk({rd_v[30:0], irq}, 32'h2);
      wr(`RTC_IDX_INT_MASK, 32'h1);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(`RTC_IDX_INT_STATUS, 32'h1);
      rd(`RTC_IDX_INT_STATUS);
      chk({rd_v[30:0], irq}, 32'h0);
      // Bypass, disable, warm-up restart, mode change
      wr(`RTC_IDX_CONTROL, 32'h9000);
      repeat (3) @(posedge aclk);
      chk({30'h0, osc_en, circ_en}, 32'h1);
      wait_rdy;
      wr(`RTC_IDX_CONTROL, 32'hC000);
      repeat (3) @(posedge aclk);
      chk({29'h0, osc_en, circ_en, slow_rdy}, 32'h0);
      wr(`RTC_IDX_CONTROL, 32'h8000);
      repeat (2) @(posedge aclk);
      chk({29'h0, osc_en, circ_en, slow_rdy}, 32'h6);
      wait_rdy;
      wr(`RTC_IDX_CONTROL, 32'h8400);
      repeat (2) @(posedge aclk);
      chk({31'h0, slow_rdy}, 32'h0);
      wait_rdy;
      // Second reset: trim clears, seconds survive
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      m_ctrl = 32'h0;
      m_trim = 32'h0;
      rd(`RTC_IDX_TRIM);
      chk(rd_v, m_trim);
      rd(`RTC_IDX_SEC_HIGH);
      chk(rd_v, 32'h1235);
      end_sim;
   end
endmodule // rtc_counter_and_osc_control_bench

// Checker attached to every instance of the block
bind rtc_counter_and_osc_control rtc_counter_and_osc_control_assertions #(.WARMUP_CYCLES(WARMUP_CYCLES)) chk_i (.*);
